// File: pkg/rar_defs.svh
// Register offsets, reset values and timing figures of the supervisor
`ifndef RAR_DEFS_SVH
`define RAR_DEFS_SVH
// Register byte offsets
`define RAR_A_CFG      8'h00
`define RAR_A_MSEL     8'h04
`define RAR_A_STAT     8'h08
`define RAR_A_CLR      8'h0c
`define RAR_A_EN       8'h10
`define RAR_A_STATE    8'h14
// Reset values
`define RAR_CFG_RST    20'h32000
`define RAR_MSEL_RST   24'h000000
// Ratio in 0.1 % units: default, top and divisor
`define RAR_RATIO_DEF  10'h320
`define RAR_RATIO_TOP  10'h3e8
`define RAR_RATIO_DIV  26'h3e8
// Attempt limit and function codes of the contact outputs
`define RAR_TRY_TOP    4'ha
`define RAR_FN_LOSS    8'h0c
`define RAR_FN_RST     8'h1e
// Ride-through settings that make a low bus restartable
`define RAR_RIDE_A     2'h1
`define RAR_RIDE_B     2'h2
// Timing: clock period, millisecond, window and quiet time
`define RAR_CLK_NS     4
`define RAR_MS_NS      1000000
`define RAR_WIN_MS     400
`define RAR_QUIET_MIN  10
`define RAR_MIN_MS     60000
`endif

// File: pkg/rar_pkg.sv
// Types shared by the supervisor and its users
package rar_pkg;
  // Settings word, high bit first in software view
  typedef struct packed {
    logic [1:0] ride;
    logic [9:0] ratio;
    logic [3:0] tries;
    logic [1:0] pad;
    logic       contact;
    logic       action;
  } rar_cfg_s;
  // Fault inputs from the power stage
  typedef struct packed {
    logic other_fault;
    logic overtorque_fault_b;
    logic overtorque_fault_a;
    logic motor_overheat;
    logic drive_overload;
    logic motor_overload;
    logic brake_transistor_fault;
    logic brake_resistor_hot;
    logic output_phase_loss_fault;
    logic supply_voltage_fault;
    logic dc_bus_low_fault;
    logic dc_bus_high_fault;
    logic fuse_blown_fault;
    logic ground_fault;
    logic overcurrent_fault;
  } rar_fault_s;
  // Sticky events
  typedef struct packed {
    logic trip;
    logic restart;
    logic loss;
  } rar_evt_s;
  // Restart sequencer
  typedef enum logic [1:0] {
    RAR_IDLE   = 2'h0,
    RAR_DIAG   = 2'h1,
    RAR_SEARCH = 2'h3,
    RAR_TRIP   = 2'h2
  } rar_state_e;
endpackage

// File: design/rar_top.sv
// Reference-loss hold and automatic restart supervisor with AHB-Lite regs
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rar_defs.svh"
// Overview of operation
// [R01] Reference is lost when it drops to a tenth or less within 400 ms.
// [R02] Loss action 0 follows the reference, 1 keeps running slower.
// [R03] In continuation the command is pre-loss speed times the ratio.
// [R04] Without the adjustable option the ratio is fixed at 80.0 percent.
// [R05] A contact output with code C is on while the reference is lost.
// [R06] A fault runs a self-test and restarts only if the test passes.
// [R07] Restarts are limited to 0..10 attempts, none by default.
// [R08] Each restart starts a speed search from the pre-fault frequency.
// [R09] Only the listed faults may restart, any other one trips.
// [R10] Low bus voltage may restart only with ride-through set to 1 or 2.
// [R11] A contact output with code 1E is on while a restart runs.
// [R12] Contact setting 1 drives the fault contact during a restart.
// [R13] Ten minutes of clean running after a restart clear the count.
// [R14] A fault reset after a trip clears the count.
// [R15] Power-up clears the count.
// [R16] Settings cannot be written while the drive runs; the output selects still can be written while running.
// [R17] At the attempt limit a restartable fault trips instead.
module rar_top #(
  parameter int  REF_W     = 12,
  parameter int  FREQ_W    = 16,
  parameter bit  ADJ_RATIO = 1'b1,
  parameter int  MS_CYC    = `RAR_MS_NS / `RAR_CLK_NS,
  parameter int  QUIET_MS  = `RAR_QUIET_MIN * `RAR_MIN_MS
) (
  // Clock, reset, enable
  input  wire logic               CLOCK,
  input  wire logic               RST_N,
  input  wire logic               CLK_EN,
  // AHB-Lite slave
  input  wire logic               HSEL,
  input  wire logic [7:0]         HADDR,
  input  wire logic [1:0]         HTRANS,
  input  wire logic               HWRITE,
  input  wire logic [2:0]         HSIZE,
  input  wire logic               HREADY,
  input  wire logic [31:0]        HWDATA,
  output logic      [31:0]        HRDATA,
  output logic                    HREADYOUT,
  output logic                    HRESP,
  output logic                    IRQ,
  // Pins: analog reference, faults, fault reset
  input  wire logic [REF_W-1:0]   REF_IN,
  input  wire rar_pkg::rar_fault_s FAULT_IN,
  input  wire logic               FAULT_RESET,
  // Speed path, same clock
  input  wire logic               RUNNING,
  input  wire logic [FREQ_W-1:0]  FREF,
  input  wire logic [FREQ_W-1:0]  RUN_FREQ,
  input  wire logic               DIAG_DONE,
  input  wire logic               DIAG_OK,
  input  wire logic               SEARCH_DONE,
  output logic      [FREQ_W-1:0]  SPEED_CMD,
  output logic      [FREQ_W-1:0]  SEARCH_FREQ,
  output logic                    DIAG_REQ,
  output logic                    RESTART_REQ,
  output logic                    TRIP,
  // Contact outputs
  output logic      [2:0]         MFO,
  output logic                    FAULT_CONTACT
);
  import rar_pkg::*;

  localparam int MSW = $clog2(MS_CYC + 1);
  localparam int QW  = $clog2(QUIET_MS + 1);
  localparam int RW  = REF_W + 4;

  // Parameter sanity
  if (REF_W < 4 || FREQ_W < 4 || MS_CYC < 2 || QUIET_MS < 1) begin : g_chk
    $error("rar_top: unsupported parameter values");
  end

  //--------------------------------------------------------------------
  // Input synchronisers and millisecond timebase
  //--------------------------------------------------------------------
  logic [REF_W-1:0] ref_m, ref_s;
  rar_fault_s       flt_m, flt_s;
  logic             frs_m, frs_s, frs_d;
  logic [MSW-1:0]   ms_cnt;
  logic             ms_tick;

  // Two flops on every pin
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ref_m <= '0;
      ref_s <= '0;
      flt_m <= '0;
      flt_s <= '0;
      frs_m <= 1'b0;
      frs_s <= 1'b0;
      frs_d <= 1'b0;
    end else if (CLK_EN) begin
      ref_m <= REF_IN;
      ref_s <= ref_m;
      flt_m <= FAULT_IN;
      flt_s <= flt_m;
      frs_m <= FAULT_RESET;
      frs_s <= frs_m;
      frs_d <= frs_s;
    end
  end

  // Millisecond tick
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ms_cnt  <= '0;
      ms_tick <= 1'b0;
    end else if (CLK_EN) begin
      ms_tick <= (ms_cnt == MSW'(MS_CYC - 1));
      ms_cnt  <= (ms_cnt == MSW'(MS_CYC - 1)) ? '0 : ms_cnt + 1'b1;
    end
  end

  //--------------------------------------------------------------------
  // Registers over AHB-Lite
  //--------------------------------------------------------------------
  rar_cfg_s    cfg;
  logic [23:0] msel;
  rar_evt_s    stat, ien, evt;
  logic        wr_q;
  logic [7:0]  addr_q;
  logic        lost;
  rar_state_e  state, next_state;
  logic [3:0]  tries;
  logic        acc, wr_cfg;
  logic [31:0] rd;
  rar_evt_s    clr;

  assign acc    = HSEL && HREADY && HTRANS[1];
  assign wr_cfg = wr_q && addr_q == `RAR_A_CFG;
  assign clr    = (wr_q && addr_q == `RAR_A_CLR) ? rar_evt_s'(HWDATA[2:0])
                                                 : '0;

  // Read mux, sampled in the address phase
  always_comb begin
    rd = '0;
    unique case (HADDR)
      `RAR_A_CFG:   rd[19:0] = cfg;
      `RAR_A_MSEL:  rd[23:0] = msel;
      `RAR_A_STAT:  rd[2:0]  = stat;
      `RAR_A_EN:    rd[2:0]  = ien;
      `RAR_A_STATE: rd[9:0]  = {RUNNING, lost, tries, 2'h0, state};
      default:      rd       = '0;
    endcase
  end

  // Address phase capture and read data
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wr_q      <= 1'b0;
      addr_q    <= '0;
      HRDATA    <= '0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else if (CLK_EN) begin
      wr_q      <= acc && HWRITE;
      addr_q    <= HADDR;
      HRDATA    <= (acc && !HWRITE) ? rd : '0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // Settings, the configuration word locked while running, output selects not
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cfg  <= rar_cfg_s'(`RAR_CFG_RST);
      msel <= `RAR_MSEL_RST;
    end else if (CLK_EN) begin
      if (wr_cfg && !RUNNING) begin // [R16]
        cfg       <= rar_cfg_s'(HWDATA[19:0]);
        cfg.pad   <= 2'h0;
        // Out-of-range values saturate
        if (HWDATA[7:4] > `RAR_TRY_TOP)
          cfg.tries <= `RAR_TRY_TOP; // [R07]
        if (HWDATA[17:8] > `RAR_RATIO_TOP)
          cfg.ratio <= `RAR_RATIO_TOP; // [R03]
      end
      if (wr_q && addr_q == `RAR_A_MSEL)
        msel <= HWDATA[23:0];
    end
  end

  // Sticky status, enable and interrupt line; a set beats a clear
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      stat <= '0;
      ien  <= '0;
      IRQ  <= 1'b0;
    end else if (CLK_EN) begin
      stat <= (stat & ~clr) | evt;
      if (wr_q && addr_q == `RAR_A_EN)
        ien <= rar_evt_s'(HWDATA[2:0]);
      IRQ  <= |(((stat & ~clr) | evt) & ien);
    end
  end

  //--------------------------------------------------------------------
  // Reference loss detection and speed hold
  //--------------------------------------------------------------------
  logic [8:0]          win_cnt;
  logic [REF_W-1:0]    base;
  logic [FREQ_W-1:0]   held;
  logic [RW-1:0]       ref10;
  logic [9:0]          ratio_eff;
  logic [FREQ_W+9:0]   scaled;
  logic                win_end;

  assign ref10     = RW'({ref_s, 3'b000}) + RW'({ref_s, 1'b0});
  assign win_end   = ms_tick && win_cnt == 9'(`RAR_WIN_MS - 1);
  assign ratio_eff = ADJ_RATIO ? cfg.ratio : `RAR_RATIO_DEF; // [R04]
  assign scaled    = (FREQ_W+10)'(held * ratio_eff)
                     / (FREQ_W+10)'(`RAR_RATIO_DIV);

  // Window base and pre-loss speed, frozen while lost
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      win_cnt <= '0;
      base    <= '0;
      held    <= '0;
    end else if (CLK_EN) begin
      if (ms_tick)
        win_cnt <= win_end ? '0 : win_cnt + 1'b1;
      if (win_end && !lost) begin
        base <= ref_s;
        held <= RUN_FREQ;
      end
    end
  end

  // Loss flag: a fall of 90 % or more since the window base
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      lost <= 1'b0;
    end else if (CLK_EN) begin
      if (!lost)
        lost <= base != '0 && ref10 <= RW'(base); // [R01]
      else
        lost <= ref10 <= RW'(base);
    end
  end

  // Speed command
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N)
      SPEED_CMD <= '0;
    else if (CLK_EN)
      SPEED_CMD <= (lost && cfg.action) ? FREQ_W'(scaled) // [R02] [R03]
                                        : FREF;
  end

  //--------------------------------------------------------------------
  // Restart sequencer
  //--------------------------------------------------------------------
  logic              any, bad, elig, ride_ok, fault_run, reset_edge;
  logic [FREQ_W-1:0] pre_freq;
  logic              armed;
  logic [QW-1:0]     quiet;

  assign ride_ok    = cfg.ride == `RAR_RIDE_A || cfg.ride == `RAR_RIDE_B;
  assign any        = |flt_s;
  assign bad        = flt_s.other_fault // [R09]
                      || (flt_s.dc_bus_low_fault && !ride_ok); // [R10]
  assign elig       = any && !bad;
  assign fault_run  = state == RAR_IDLE && any && RUNNING;
  assign reset_edge = frs_s && !frs_d && !any;

  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      RAR_IDLE:
        if (fault_run)
          next_state = (elig && tries < cfg.tries) ? RAR_DIAG // [R06]
                                                   : RAR_TRIP; // [R17]
      RAR_DIAG:
        if (DIAG_DONE)
          next_state = DIAG_OK ? RAR_SEARCH : RAR_TRIP; // [R06]
      RAR_SEARCH:
        if (SEARCH_DONE)
          next_state = RAR_IDLE;
      RAR_TRIP:
        if (reset_edge)
          next_state = RAR_IDLE;
    endcase
  end

  // State and pre-fault frequency
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state    <= RAR_IDLE;
      pre_freq <= '0;
    end else if (CLK_EN) begin
      state <= next_state;
      if (state == RAR_IDLE && !any)
        pre_freq <= RUN_FREQ;
    end
  end

  // Attempt count and quiet-run timer
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tries <= '0; // [R15]
      armed <= 1'b0;
      quiet <= '0;
    end else if (CLK_EN) begin
      if (state == RAR_DIAG && next_state == RAR_SEARCH)
        tries <= tries + 1'b1; // [R07]
      else if (state == RAR_TRIP && reset_edge)
        tries <= '0; // [R14]
      else if (armed && quiet == QW'(QUIET_MS))
        tries <= '0; // [R13]
      if (state == RAR_SEARCH && SEARCH_DONE)
        armed <= 1'b1;
      else if (state != RAR_IDLE || quiet == QW'(QUIET_MS))
        armed <= 1'b0;
      if (!armed || any || !RUNNING)
        quiet <= '0;
      else if (ms_tick)
        quiet <= quiet + 1'b1;
    end
  end

  // Sequencer outputs and events
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      DIAG_REQ      <= 1'b0;
      RESTART_REQ   <= 1'b0;
      SEARCH_FREQ   <= '0;
      TRIP          <= 1'b0;
      FAULT_CONTACT <= 1'b0;
      evt           <= '0;
    end else if (CLK_EN) begin
      DIAG_REQ    <= state == RAR_IDLE && next_state == RAR_DIAG;
      RESTART_REQ <= state == RAR_DIAG && next_state == RAR_SEARCH;
      if (state == RAR_DIAG && next_state == RAR_SEARCH)
        SEARCH_FREQ <= pre_freq; // [R08]
      TRIP          <= next_state == RAR_TRIP;
      FAULT_CONTACT <= next_state == RAR_TRIP
                       || (cfg.contact && (next_state == RAR_DIAG
                       || next_state == RAR_SEARCH)); // [R12]
      evt.loss    <= ref10 <= RW'(base) && base != '0 && !lost;
      evt.restart <= state == RAR_DIAG && next_state == RAR_SEARCH;
      evt.trip    <= state != RAR_TRIP && next_state == RAR_TRIP;
    end
  end

  //--------------------------------------------------------------------
  // Multi-function contact outputs
  //--------------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_mfo
    always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N)
        MFO[i] <= 1'b0;
      else if (CLK_EN)
        MFO[i] <= (msel[8*i +: 8] == `RAR_FN_LOSS && lost) // [R05]
                  || (msel[8*i +: 8] == `RAR_FN_RST // [R11]
                  && (state == RAR_DIAG || state == RAR_SEARCH));
    end
  end

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge CLOCK iff CLK_EN); endclocking
  default disable iff (!RST_N);

  sequence s_fault_taken;
    fault_run && elig && tries < cfg.tries;
  endsequence
  sequence s_diag_pass;
    state == RAR_DIAG && DIAG_DONE && DIAG_OK;
  endsequence

  a_loss_rises: assert property ($rose(lost) |-> // [R01]
    $past(ref10 <= RW'(base) && base != '0))
    else $error("loss flag set without a 90 percent fall");
  a_hold_speed: assert property (lost && cfg.action && $stable(held) // [R03]
    |=> SPEED_CMD == FREQ_W'($past(scaled)))
    else $error("held speed not scaled by ratio");
  a_follow_ref: assert property (!cfg.action |=> SPEED_CMD == $past(FREF))
    else $error("speed does not follow reference"); // [R02]
  a_fixed_ratio: assert property (!ADJ_RATIO |-> // [R04]
    ratio_eff == `RAR_RATIO_DEF)
    else $error("ratio not fixed");
  a_mfo_loss: assert property (msel[7:0] == `RAR_FN_LOSS && lost // [R05]
    |=> MFO[0])
    else $error("loss contact not on");
  a_diag_request: assert property (s_fault_taken // [R06]
    |=> state == RAR_DIAG && DIAG_REQ)
    else $error("eligible fault did not request a self-test");
  a_restart_path: assert property (s_diag_pass // [R08]
    |=> RESTART_REQ && SEARCH_FREQ == $past(pre_freq, 1))
    else $error("restart not started from pre-fault frequency");
  a_diag_fail: assert property (state == RAR_DIAG && DIAG_DONE // [R06]
    && !DIAG_OK |=> state == RAR_TRIP && TRIP)
    else $error("failed self-test did not trip");
  a_limit_trip: assert property (fault_run && tries >= cfg.tries // [R17]
    |=> state == RAR_TRIP)
    else $error("restart beyond limit");
  a_inelig_trip: assert property (fault_run && bad |=> TRIP) // [R09]
    else $error("ineligible fault restarted");
  a_reset_clear: assert property (state == RAR_TRIP && reset_edge // [R14]
    |=> tries == '0 && state == RAR_IDLE)
    else $error("fault reset did not clear count");
  a_cfg_lock: assert property (wr_cfg && RUNNING |=> $stable(cfg)) // [R16]
    else $error("settings changed while running");
  a_contact_sel: assert property (state == RAR_SEARCH && // [R12]
    $stable(state) |-> FAULT_CONTACT == cfg.contact)
    else $error("fault contact wrong during restart");
endmodule // rar_top
`default_nettype wire

// File: verification/rar_drive_model.sv
// Drive-side partner: answers self-test and speed search requests
`timescale 1ns/1ps
`default_nettype none
module rar_drive_model (
  // Clock and reset
  input  wire logic CLOCK,
  input  wire logic RST_N,
  // Bench controls: answer pace and self-test verdict
  input  wire logic slow,
  input  wire logic diag_bad,
  // Requests from the supervisor and answers to it
  input  wire logic DIAG_REQ,
  input  wire logic RESTART_REQ,
  output logic      DIAG_DONE,
  output logic      DIAG_OK,
  output logic      SEARCH_DONE
);
  int dcnt;
  int scnt;

  // Answers only after a request; verdict toggles while meaningless
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      dcnt        <= 0;
      scnt        <= 0;
      DIAG_DONE   <= 1'b0;
      DIAG_OK     <= 1'b0;
      SEARCH_DONE <= 1'b0;
    end else begin
      DIAG_DONE   <= (dcnt == 1);
      SEARCH_DONE <= (scnt == 1);
      DIAG_OK     <= (dcnt == 1) ? ~diag_bad : ~DIAG_OK;
      if (DIAG_REQ)
        dcnt <= slow ? 15 : 3;
      else if (dcnt != 0)
        dcnt <= dcnt - 1;
      if (RESTART_REQ)
        scnt <= slow ? 20 : 8;  // Leaves time for the fault to clear
      else if (scnt != 0)
        scnt <= scnt - 1;
    end
  end
endmodule // rar_drive_model
`default_nettype wire

// File: verification/rar_top_tb.sv
// Self-checking bench for the reference-loss and restart supervisor
`timescale 1ns/1ps
`default_nettype none
`include "rar_defs.svh"
module rar_top_tb;
  import rar_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        CLOCK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic        FAULT_RESET = 1'b0, RUNNING = 1'b0, rd_take = 1'b0;
  logic        slow = 1'b0, diag_bad = 1'b0;
  logic [7:0]  HADDR = 8'h00;
  logic [1:0]  HTRANS = 2'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [11:0] REF_IN = 12'h3e8;
  logic [15:0] FREF = 16'h0, RUN_FREQ = 16'h0;
  rar_fault_s  FAULT_IN = '0;
  logic [31:0] HRDATA;
  logic [15:0] SPEED_CMD, SEARCH_FREQ, SPEED_FIX;
  logic [2:0]  MFO;
  logic        HREADYOUT, HRESP, IRQ, DIAG_DONE, DIAG_OK, SEARCH_DONE;
  logic        DIAG_REQ, RESTART_REQ, TRIP, FAULT_CONTACT;
  logic [31:0] exp_q[$], msk_q[$];
  string       nm_q[$];
  int          mismatches = 0, checks_done = 0, cycles = 0;
  logic [9:0]  ratio;
  logic [15:0] fref;

  rar_top #(.MS_CYC(10), .QUIET_MS(5)) rar_top_inst (
    .CLOCK(CLOCK), .RST_N(RST_N), .CLK_EN(1'b1), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
    .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ), .REF_IN(REF_IN),
    .FAULT_IN(FAULT_IN), .FAULT_RESET(FAULT_RESET), .RUNNING(RUNNING),
    .FREF(FREF), .RUN_FREQ(RUN_FREQ), .DIAG_DONE(DIAG_DONE),
    .DIAG_OK(DIAG_OK), .SEARCH_DONE(SEARCH_DONE), .SPEED_CMD(SPEED_CMD),
    .SEARCH_FREQ(SEARCH_FREQ), .DIAG_REQ(DIAG_REQ),
    .RESTART_REQ(RESTART_REQ), .TRIP(TRIP), .MFO(MFO),
    .FAULT_CONTACT(FAULT_CONTACT));

  // Second supervisor without the adjustable ratio, same stimulus
  rar_top #(.ADJ_RATIO(1'b0), .MS_CYC(10), .QUIET_MS(5)) rar_top_fixed_inst (
    .CLOCK(CLOCK), .RST_N(RST_N), .CLK_EN(1'b1), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
    .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(), .HREADYOUT(),
    .HRESP(), .IRQ(), .REF_IN(REF_IN), .FAULT_IN(FAULT_IN),
    .FAULT_RESET(FAULT_RESET), .RUNNING(RUNNING), .FREF(FREF),
    .RUN_FREQ(RUN_FREQ), .DIAG_DONE(DIAG_DONE), .DIAG_OK(DIAG_OK),
    .SEARCH_DONE(SEARCH_DONE), .SPEED_CMD(SPEED_FIX), .SEARCH_FREQ(),
    .DIAG_REQ(), .RESTART_REQ(), .TRIP(), .MFO(), .FAULT_CONTACT());

  rar_drive_model rar_drive_model_inst (
    .CLOCK(CLOCK), .RST_N(RST_N), .slow(slow), .diag_bad(diag_bad),
    .DIAG_REQ(DIAG_REQ), .RESTART_REQ(RESTART_REQ),
    .DIAG_DONE(DIAG_DONE), .DIAG_OK(DIAG_OK), .SEARCH_DONE(SEARCH_DONE));

  // ------------------------------------------------------------------
  // Clock, timeout, read-data watcher
  // ------------------------------------------------------------------
  always #2 CLOCK = ~CLOCK;

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      final_report;
    end
  end

  // Takes the oldest expected read value when read data stands
  always @(posedge CLOCK) begin
    if (rd_take && HREADYOUT && exp_q.size() > 0) begin
      chk(nm_q.pop_front(), exp_q.pop_front(), HRDATA & msk_q.pop_front());
      chk("hresp", 32'h0, 32'(HRESP));
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single AHB-Lite transfer; a read notes its masked expectation
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input string nm);
    @(posedge CLOCK);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR  <= a;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HSEL    <= 1'b0;
    HTRANS  <= 2'h0;
    HWDATA  <= d;
    rd_take <= ~w;
    if (!w) begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
      nm_q.push_back(nm);
    end
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    rd_take <= 1'b0;
  endtask

  // Settings may only be written while stopped
  task automatic cfg(input logic [1:0] ride, input logic [9:0] rt,
                     input logic [3:0] tr, input logic con, input logic act);
    RUNNING <= 1'b0;
    bus(1'b1, `RAR_A_CFG, {12'h0, ride, rt, tr, 2'h0, con, act}, 0, "");
    RUNNING <= 1'b1;
  endtask

  // Waits for one of DIAG_REQ, RESTART_REQ, TRIP at a bounded count
  task automatic await(input int k, input int n, output bit got);
    got = 1'b0;
    repeat (n) begin
      @(posedge CLOCK);
      if ((k == 0 && DIAG_REQ) || (k == 1 && RESTART_REQ) || (k == 2 && TRIP)) begin
        got = 1'b1;
        break;
      end
    end
  endtask

  // Fault on bit b; kind 0 trips, 1 restarts, 2 fails its self-test
  task automatic hit_fault(input int b, input int kind, input logic con);
    bit          got;
    logic [15:0] rf;
    rf = 16'($urandom());
    RUN_FREQ <= rf;
    repeat (4) @(posedge CLOCK);
    FAULT_IN <= rar_fault_s'(15'h1 << b);
    await(kind == 0 ? 2 : 0, 20, got);
    chk("reaction", 32'h1, 32'(got));
    if (kind == 1) begin
      await(1, 40, got);
      chk("restart", 32'h1, 32'(got));
      chk("search_freq", 32'(rf), 32'(SEARCH_FREQ));
      chk("mfo_restart", 32'h3, 32'(MFO[2:1]));
      chk("contact", 32'(con), 32'(FAULT_CONTACT));
      FAULT_IN <= '0;
      repeat (25) @(posedge CLOCK);
    end else begin
      if (kind == 2)
        await(2, 40, got);
      chk("trip", 32'h1, 32'(TRIP));
      FAULT_IN <= '0;
      repeat (5) @(posedge CLOCK);
      FAULT_RESET <= 1'b1;
      repeat (5) @(posedge CLOCK);
      FAULT_RESET <= 1'b0;
      repeat (3) @(posedge CLOCK);
      chk("trip_reset", 32'h0, 32'(TRIP));
      bus(1'b0, `RAR_A_STATE, 32'h0, 32'hf3, "tries_reset");
    end
  endtask

  task automatic final_report;
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(66));
    repeat (10) @(posedge CLOCK);
    RST_N <= 1'b1;
    bus(1'b0, `RAR_A_CFG, `RAR_CFG_RST, 32'hffffffff, "cfg_rst");
    bus(1'b0, `RAR_A_MSEL, 32'h0, 32'hffffffff, "msel_rst");
    bus(1'b1, 8'h40, 32'hffffffff, 0, "");
    bus(1'b0, 8'h40, 32'h0, 32'hffffffff, "unmapped");
    bus(1'b1, `RAR_A_MSEL, 32'h001e1e0c, 0, "");
    bus(1'b1, `RAR_A_EN, 32'h1, 0, "");
    RUNNING <= 1'b1;
    bus(1'b1, `RAR_A_CFG, 32'h000000f3, 0, "");
    bus(1'b0, `RAR_A_CFG, `RAR_CFG_RST, 32'hffffffff, "cfg_lock");
    cfg(2'h1, 10'h3ff, 4'hf, 1'b0, 1'b0);
    bus(1'b0, `RAR_A_CFG, 32'h0007e8a0, 32'hffffffff, "cfg_sat");
    // Loss of reference, both actions, with interrupt handling
    // Running frequency captured at the first window end as pre-loss speed
    RUN_FREQ <= 16'($urandom());
    wait (cycles > 4120);
    for (int a = 1; a >= 0; a--) begin
      ratio = 10'($urandom_range(1000));
      fref  = 16'($urandom());
      cfg(2'h0, ratio, 4'h0, 1'b0, a[0]);
      FREF   <= fref;
      REF_IN <= 12'h065;
      repeat (6) @(posedge CLOCK);
      bus(1'b0, `RAR_A_STATE, 32'h0, 32'h100, "lost_edge");
      REF_IN <= 12'h064;
      repeat (6) @(posedge CLOCK);
      bus(1'b0, `RAR_A_STATE, 32'h100, 32'h100, "lost");
      chk("speed", a[0] ? int'(RUN_FREQ) * int'(ratio) / 1000 : fref,
          SPEED_CMD);
      chk("speed_fix", a[0] ? int'(RUN_FREQ) * 4 / 5 : fref, SPEED_FIX);
      chk("mfo_loss", 32'h1, 32'(MFO));
      chk("irq", 32'h1, 32'(IRQ));
      bus(1'b1, `RAR_A_EN, 32'h0, 0, "");
      repeat (2) @(posedge CLOCK);
      chk("irq_mask", 32'h0, 32'(IRQ));
      bus(1'b1, `RAR_A_EN, 32'h1, 0, "");
      bus(1'b1, `RAR_A_CLR, 32'h7, 0, "");
      repeat (2) @(posedge CLOCK);
      chk("irq_clr", 32'h0, 32'(IRQ));
      bus(1'b0, `RAR_A_STAT, 32'h0, 32'h1, "stat_clr");
      REF_IN <= 12'h3e8;
      repeat (6) @(posedge CLOCK);
      bus(1'b0, `RAR_A_STATE, 32'h0, 32'h100, "regain");
      chk("speed_follow", 32'(fref), 32'(SPEED_CMD));
      chk("mfo_regain", 32'h0, 32'(MFO[0]));
    end
    // Every restartable fault, both contact settings, both paces
    for (int b = 0; b < 14; b++) begin
      slow <= b[1];
      cfg(b[0] ? 2'h2 : 2'h1, 10'h320, 4'ha, b[0], 1'b0);
      hit_fault(b, 1, b[0]);
      bus(1'b0, `RAR_A_STATE, 32'h10, 32'hf3, "tries_one");
      repeat (60) @(posedge CLOCK);
      bus(1'b0, `RAR_A_STATE, 32'h0, 32'hf3, "tries_quiet");
    end
    // Refusals, attempt limit and failing self-test
    cfg(2'h0, 10'h320, 4'ha, 1'b1, 1'b0);
    hit_fault(4, 0, 1'b1);
    hit_fault(14, 0, 1'b1);
    cfg(2'h0, 10'h320, 4'h0, 1'b1, 1'b0);
    hit_fault(0, 0, 1'b1);
    cfg(2'h0, 10'h320, 4'h2, 1'b1, 1'b0);
    hit_fault(1, 1, 1'b1);
    hit_fault(2, 1, 1'b1);
    hit_fault(3, 0, 1'b1);
    diag_bad <= 1'b1;
    hit_fault(5, 2, 1'b1);
    final_report;
  end
endmodule // rar_top_tb
`default_nettype wire
